// *** inc/stream4_attr_pkg.sv ***
// Constants and types shared by the stream four attribute bank.
// Function
// (RULE_01) Hold 16-bit frame line total.
// (RULE_02) Polarity bit 1 selects vertical sync polarity.
// (RULE_03) Polarity bit 0 selects horizontal sync polarity.
// (RULE_04) Hold 15-bit horizontal sync width in clocks.
// (RULE_05) Hold 15-bit vertical sync width in lines.
// (RULE_06) Hold 16-bit active pixels per line.
// (RULE_07) Hold 16-bit active lines per frame.
// (RULE_08) Hold 16-bit clocks from hsync to active.
// (RULE_09) Hold 16-bit lines from vsync to active.
// (RULE_10) Attribute byte, bit 0 flags synchronous clocking.
// (RULE_11) Attribute byte bits 2:1 give component format.
// (RULE_12) Hold 16-bit line clock total.
// (RULE_13) Byte bits: range, colorimetry, depth per component.
// (RULE_14) Reads return last write, upper bits zero.
package stream4_attr_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int FIELD_W = 16;
    localparam int REG_COUNT = 10;
    localparam int STATUS_W = 4;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        IDX_LINE_CLOCK_TOTAL = 4'h0,
        IDX_FRAME_LINE_TOTAL = 4'h1,
        IDX_SYNC_POLARITY = 4'h2,
        IDX_HSYNC_WIDTH = 4'h3,
        IDX_VSYNC_WIDTH = 4'h4,
        IDX_ACTIVE_PIXELS = 4'h5,
        IDX_ACTIVE_LINES = 4'h6,
        IDX_HSYNC_TO_ACTIVE = 4'h7,
        IDX_VSYNC_TO_ACTIVE = 4'h8,
        IDX_ATTRIBUTE_BYTE0 = 4'h9,
        IDX_NONE = 4'hf
    } reg_idx_t;

    typedef enum logic [0:0] {
        PORT_IDLE = 1'b0,
        PORT_ACK = 1'b1
    } port_state_t;

    typedef logic [ADDR_W-1:0] offset_arr_t [REG_COUNT];
    typedef logic [FIELD_W-1:0] mask_arr_t [REG_COUNT];

    localparam offset_arr_t REG_OFFSET = '{
        12'h5a0, 12'h5a4, 12'h5a8, 12'h5ac, 12'h5b0,
        12'h5b4, 12'h5b8, 12'h5bc, 12'h5c0, 12'h5c4
    };
    localparam mask_arr_t REG_MASK = '{
        16'hffff, 16'hffff, 16'h0003, 16'h7fff, 16'h7fff,
        16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h00ff
    };
    localparam logic [FIELD_W-1:0] REG_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] OFS_TIMING_STATUS = 12'h7f0;

    ////////////////////////////////////////////////////////////////////////
    localparam int POL_HSYNC_BIT = 0;
    localparam int POL_VSYNC_BIT = 1;
    localparam int SYNC_WIDTH_MSB = 14;
    localparam int B0_SYNC_CLOCK_BIT = 0;
    localparam int B0_FORMAT_LSB = 1;
    localparam int B0_FORMAT_MSB = 2;
    localparam int B0_RANGE_BIT = 3;
    localparam int B0_COLORIMETRY_BIT = 4;
    localparam int B0_DEPTH_LSB = 5;
    localparam int B0_DEPTH_MSB = 7;
    localparam int ST_H_FITS = 0;
    localparam int ST_V_FITS = 1;
    localparam int ST_HSYNC_FITS = 2;
    localparam int ST_VSYNC_FITS = 3;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [BE_W-1:0] be;
    } bus_access_t;

    typedef struct packed {
        logic [15:0] line_clock_total;
        logic [15:0] frame_line_total;
        logic vsync_polarity;
        logic hsync_polarity;
        logic [14:0] hsync_width;
        logic [14:0] vsync_width;
        logic [15:0] active_pixels;
        logic [15:0] active_lines;
        logic [15:0] hsync_to_active;
        logic [15:0] vsync_to_active;
    } stream_timing_t;

    typedef struct packed {
        logic [2:0] bit_depth;
        logic colorimetry;
        logic dynamic_range;
        logic [1:0] component_format;
        logic sync_clock;
    } attr_fields_t;

endpackage : stream4_attr_pkg

// *** rtl/avalon_word_port.sv ***
// Avalon-MM slave front end that answers each request after one cycle.
`timescale 1ns/10ps
module avalon_word_port
    import stream4_attr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DATA_W-1:0] writedata,
    input wire logic [BE_W-1:0] byteenable,
    input wire logic [DATA_W-1:0] read_word,
    output bus_access_t access,
    output logic [DATA_W-1:0] readdata,
    output logic waitrequest
);

    port_state_t state_reg;
    port_state_t state_next;
    wire logic take;

    // A request is taken once, on the edge that starts the answer cycle.
    assign take = (state_reg == PORT_IDLE) && (read || write);
    assign access.wr = (state_reg == PORT_IDLE) && write;
    assign access.rd = (state_reg == PORT_IDLE) && read;
    assign access.addr = address;
    assign access.data = writedata;
    assign access.be = byteenable;

    always_comb begin
        case (state_reg)
            PORT_IDLE: state_next = take ? PORT_ACK : PORT_IDLE;
            PORT_ACK: state_next = PORT_IDLE;
            default: state_next = PORT_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= PORT_IDLE;
            waitrequest <= 1'b1;
            readdata <= '0;
        end else begin
            state_reg <= state_next;
            waitrequest <= !take;
            if (access.rd) begin
                readdata <= read_word;
            end
        end
    end

endmodule : avalon_word_port

// *** rtl/timing_check.sv ***
// Registered consistency flags over the programmed frame timing.
`timescale 1ns/10ps
module timing_check
    import stream4_attr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input stream_timing_t timing,
    output logic [STATUS_W-1:0] status
);

    wire logic [STATUS_W-1:0] status_next;

    // Offset plus span must not run past the total.
    function automatic logic fits(input logic [15:0] start,
                                  input logic [15:0] span,
                                  input logic [15:0] limit);
        logic [16:0] sum;
        sum = {1'b0, start} + {1'b0, span};
        return sum <= {1'b0, limit};
    endfunction : fits

    assign status_next[ST_H_FITS] = fits(timing.hsync_to_active,
        timing.active_pixels, timing.line_clock_total);
    assign status_next[ST_V_FITS] = fits(timing.vsync_to_active,
        timing.active_lines, timing.frame_line_total);
    assign status_next[ST_HSYNC_FITS] =
        {1'b0, timing.hsync_width} <= timing.hsync_to_active;
    assign status_next[ST_VSYNC_FITS] =
        {1'b0, timing.vsync_width} <= timing.vsync_to_active;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status <= '0;
        end else begin
            status <= status_next;
        end
    end

endmodule : timing_check

// *** rtl/stream4_video_timing_attributes.sv ***
// Stream four video timing and attribute register bank on Avalon-MM.
`timescale 1ns/10ps
module stream4_video_timing_attributes
    import stream4_attr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DATA_W-1:0] writedata,
    input wire logic [BE_W-1:0] byteenable,
    output logic [DATA_W-1:0] readdata,
    output logic waitrequest,
    output stream_timing_t timing,
    output attr_fields_t attr_fields,
    output logic [7:0] attr_byte0,
    output logic [STATUS_W-1:0] timing_status,
    output logic config_update
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    bus_access_t access;
    logic [DATA_W-1:0] read_word;
    logic [FIELD_W-1:0] store_reg [REG_COUNT];
    logic [FIELD_W-1:0] store_next [REG_COUNT];
    logic config_update_next;
    wire reg_idx_t hit_index;
    wire logic hit_status;
    wire logic hit_attr;
    wire logic write_take;
    wire logic [FIELD_W-1:0] store_word;
    wire logic [DATA_W-1:0] status_word;
    wire logic [DATA_W-1:0] attr_word;

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Maps a byte address onto a register index, or none.
    function automatic reg_idx_t index_of(input logic [ADDR_W-1:0] a);
        reg_idx_t r;
        r = IDX_NONE;
        for (int i = 0; i < REG_COUNT; i++) begin
            if (a == REG_OFFSET[i]) begin
                r = reg_idx_t'(i[3:0]);
            end
        end
        return r;
    endfunction : index_of

    // Replaces only the byte lanes that the master enables.
    function automatic logic [FIELD_W-1:0] merge_lanes(
        input logic [FIELD_W-1:0] old_value,
        input logic [FIELD_W-1:0] new_value,
        input logic [1:0] lanes);
        logic [FIELD_W-1:0] r;
        r = old_value;
        if (lanes[0]) begin
            r[7:0] = new_value[7:0];
        end
        if (lanes[1]) begin
            r[15:8] = new_value[15:8];
        end
        return r;
    endfunction : merge_lanes

    ////////////////////////////////////////////////////////////////////////
    // Bus front end.

    avalon_word_port port_inst (
        .clock(clock),
        .rst(rst),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .byteenable(byteenable),
        .read_word(read_word),
        .access(access),
        .readdata(readdata),
        .waitrequest(waitrequest)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode.

    assign hit_index = index_of(access.addr);
    assign hit_attr = (hit_index != IDX_NONE);
    assign hit_status = (access.addr == OFS_TIMING_STATUS);
    assign write_take = access.wr && hit_attr;

    ////////////////////////////////////////////////////////////////////////
    // Register storage.

    // Unused upper bits are masked off so they can never read back. [RULE_14]
    always_comb begin
        for (int i = 0; i < REG_COUNT; i++) begin
            store_next[i] = store_reg[i];
            if (write_take && hit_index == reg_idx_t'(i[3:0])) begin
                store_next[i] = merge_lanes(store_reg[i],
                    access.data[FIELD_W-1:0], access.be[1:0])
                    & REG_MASK[i]; // [RULE_14]
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                store_reg[i] <= REG_RESET;
            end
        end else begin
            for (int i = 0; i < REG_COUNT; i++) begin
                store_reg[i] <= store_next[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read selection.

    assign store_word = hit_attr ? store_reg[hit_index] : REG_RESET;
    assign attr_word = {{(DATA_W-FIELD_W){1'b0}}, store_word}; // [RULE_14]
    assign status_word = {{(DATA_W-STATUS_W){1'b0}}, timing_status};

    // Unmapped addresses read as zero and ignore writes.
    assign read_word = hit_status ? status_word : attr_word;

    ////////////////////////////////////////////////////////////////////////
    // Timing view for the framing logic.

    // Horizontal line length in clocks. [RULE_12]
    assign timing.line_clock_total = store_reg[IDX_LINE_CLOCK_TOTAL];
    // Lines per frame including blanking. [RULE_01]
    assign timing.frame_line_total = store_reg[IDX_FRAME_LINE_TOTAL];
    assign timing.vsync_polarity =
        store_reg[IDX_SYNC_POLARITY][POL_VSYNC_BIT]; // [RULE_02]
    assign timing.hsync_polarity =
        store_reg[IDX_SYNC_POLARITY][POL_HSYNC_BIT]; // [RULE_03]
    assign timing.hsync_width =
        store_reg[IDX_HSYNC_WIDTH][SYNC_WIDTH_MSB:0]; // [RULE_04]
    assign timing.vsync_width =
        store_reg[IDX_VSYNC_WIDTH][SYNC_WIDTH_MSB:0]; // [RULE_05]
    assign timing.active_pixels = store_reg[IDX_ACTIVE_PIXELS]; // [RULE_06]
    assign timing.active_lines = store_reg[IDX_ACTIVE_LINES]; // [RULE_07]
    assign timing.hsync_to_active =
        store_reg[IDX_HSYNC_TO_ACTIVE]; // [RULE_08]
    assign timing.vsync_to_active =
        store_reg[IDX_VSYNC_TO_ACTIVE]; // [RULE_09]

    ////////////////////////////////////////////////////////////////////////
    // Attribute byte fields.

    assign attr_byte0 = store_reg[IDX_ATTRIBUTE_BYTE0][7:0]; // [RULE_10]
    assign attr_fields.sync_clock =
        store_reg[IDX_ATTRIBUTE_BYTE0][B0_SYNC_CLOCK_BIT]; // [RULE_10]
    assign attr_fields.component_format =
        store_reg[IDX_ATTRIBUTE_BYTE0][B0_FORMAT_MSB:B0_FORMAT_LSB]; // [RULE_11]
    assign attr_fields.dynamic_range =
        store_reg[IDX_ATTRIBUTE_BYTE0][B0_RANGE_BIT]; // [RULE_13]
    assign attr_fields.colorimetry =
        store_reg[IDX_ATTRIBUTE_BYTE0][B0_COLORIMETRY_BIT]; // [RULE_13]
    assign attr_fields.bit_depth =
        store_reg[IDX_ATTRIBUTE_BYTE0][B0_DEPTH_MSB:B0_DEPTH_LSB]; // [RULE_13]

    ////////////////////////////////////////////////////////////////////////
    // Consistency status and update notice.

    timing_check check_inst (
        .clock(clock),
        .rst(rst),
        .timing(timing),
        .status(timing_status)
    );

    // Tells the framing logic that a stored register has just been written, whether or not its value changed.
    assign config_update_next = write_take;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            config_update <= 1'b0;
        end else begin
            config_update <= config_update_next;
        end
    end

endmodule : stream4_video_timing_attributes

// *** verification/stream4_attr_props.sv ***
// Port checker for the stream four attribute bank.
`timescale 1ns/10ps
module stream4_attr_props
    import stream4_attr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DATA_W-1:0] writedata,
    input wire logic [BE_W-1:0] byteenable,
    input wire logic [DATA_W-1:0] readdata,
    input wire logic waitrequest,
    input stream_timing_t timing,
    input attr_fields_t attr_fields,
    input wire logic [7:0] attr_byte0,
    input wire logic [STATUS_W-1:0] timing_status,
    input wire logic config_update
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire logic take_w = write && waitrequest;
    wire logic full_w = take_w && byteenable[1:0] == 2'b11;
    ////////////////////////////////////////////////////////////////////////
    req_answer_a:
        assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("request not answered in one cycle");
    line_total_a:
        assert property (full_w && address == 12'h5a4 |=> timing.frame_line_total == $past(writedata[15:0]))
        else $error("frame line total not stored");
    polarity_a:
        assert property (take_w && byteenable[0] && address == 12'h5a8 |=> {timing.vsync_polarity, timing.hsync_polarity} == $past(writedata[1:0]))
        else $error("sync polarity not stored");
    hsync_width_a:
        assert property (full_w && address == 12'h5ac |=> timing.hsync_width == $past(writedata[14:0]))
        else $error("hsync width not stored");
    vsync_start_a:
        assert property (full_w && address == 12'h5c0 |=> timing.vsync_to_active == $past(writedata[15:0]))
        else $error("vsync to active not stored");
    attr_byte_a:
        assert property (take_w && byteenable[0] && address == 12'h5c4 |=> attr_byte0 == $past(writedata[7:0]) && config_update)
        else $error("attribute byte not stored");
    attr_fields_a:
        assert property (attr_fields == attr_byte0)
        else $error("attribute fields differ from byte");
    hold_value_a:
        assert property (!take_w |=> $stable(timing) && $stable(attr_byte0))
        else $error("storage changed without write");
    unmapped_read_a:
        assert property (read && waitrequest && address == 12'h5c8 |=> readdata == 32'h0)
        else $error("unmapped read not zero");
    update_pulse_a:
        assert property (config_update |-> !waitrequest && $past(write))
        else $error("update pulse without write");
    cover property (take_w ##1 config_update);
    cover property (read && waitrequest ##1 !waitrequest);
    cover property (take_w && byteenable == 4'h2);
endmodule : stream4_attr_props

bind stream4_video_timing_attributes stream4_attr_props props_u (
    .clock, .rst, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .timing, .attr_fields, .attr_byte0,
    .timing_status, .config_update
);

// *** verification/tb_top.sv ***
// Self-checking bench for the stream four attribute bank.
`timescale 1ns/10ps
module tb_top
    import stream4_attr_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [DATA_W-1:0] writedata = '0;
    logic [BE_W-1:0] byteenable = '0;
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
    stream_timing_t timing;
    attr_fields_t attr_fields;
    logic [7:0] attr_byte0;
    logic [STATUS_W-1:0] timing_status;
    logic config_update;
    logic [DATA_W-1:0] expq [$];
    logic [DATA_W-1:0] d;
    logic [15:0] ev [10];
    logic [3:0] st;
    int fails = 0;
    int checks = 0;
    logic [11:0] ofs [10] = '{12'h5a0, 12'h5a4, 12'h5a8, 12'h5ac,
        12'h5b0, 12'h5b4, 12'h5b8, 12'h5bc, 12'h5c0, 12'h5c4};
    logic [15:0] msk [10] = '{16'hffff, 16'hffff, 16'h0003, 16'h7fff,
        16'h7fff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h00ff};

    always #12.5 clock = ~clock;

    stream4_video_timing_attributes dut_u (
        .clock, .rst, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .timing, .attr_fields, .attr_byte0,
        .timing_status, .config_update
    );

    ////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task acc(input logic w, input logic [11:0] a, input logic [31:0] wd,
             input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clock);
        write <= w;
        read <= !w;
        address <= a;
        writedata <= wd;
        byteenable <= b;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) fails++;
        write <= 1'b0;
        read <= 1'b0;
    endtask : acc

    task rd(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        acc(1'b0, a, $urandom(), 4'hf);
    endtask : rd

    task conclude;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    // Read answers are compared in the cycle waitrequest is low.
    always @(posedge clock) begin
        if (read && waitrequest === 1'b0 && expq.size() > 0) begin
            chk("readdata", expq.pop_front(), readdata);
        end
    end

    initial begin
        repeat (5000) @(posedge clock);
        fails++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h8cc1));
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) rd(ofs[i], 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 10; i++) begin
            d = $urandom();
            ev[i] = d[15:0] & msk[i];
            acc(1'b1, ofs[i], d, 4'hf);
            rd(ofs[i], {16'h0, ev[i]});
        end
        chk("line total", ev[1], timing.frame_line_total);
        chk("vsync pol", ev[2][1], timing.vsync_polarity);
        chk("hsync pol", ev[2][0], timing.hsync_polarity);
        chk("hsync width", ev[3], timing.hsync_width);
        chk("vsync width", ev[4], timing.vsync_width);
        chk("pixels", ev[5], timing.active_pixels);
        chk("lines", ev[6], timing.active_lines);
        chk("h start", ev[7], timing.hsync_to_active);
        chk("v start", ev[8], timing.vsync_to_active);
        chk("sync clock", ev[9][0], attr_fields.sync_clock);
        chk("format", ev[9][2:1], attr_fields.component_format);
        chk("range", ev[9][3], attr_fields.dynamic_range);
        chk("colorimetry", ev[9][4], attr_fields.colorimetry);
        chk("depth", ev[9][7:5], attr_fields.bit_depth);
        chk("line clocks", ev[0], timing.line_clock_total);
        chk("attr byte", ev[9], attr_byte0);
        st[0] = ({1'b0, ev[7]} + {1'b0, ev[5]}) <= {1'b0, ev[0]};
        st[1] = ({1'b0, ev[8]} + {1'b0, ev[6]}) <= {1'b0, ev[1]};
        st[2] = ev[3] <= ev[7];
        st[3] = ev[4] <= ev[8];
        chk("status", st, timing_status);
        rd(12'h7f0, {28'h0, st});
        $display("test random readback done");
        acc(1'b1, 12'h5b4, 32'h1234, 4'hf);
        acc(1'b1, 12'h5b4, 32'hffffabcd, 4'h1);
        rd(12'h5b4, 32'h12cd);
        acc(1'b1, 12'h5b4, 32'h5600, 4'h2);
        rd(12'h5b4, 32'h56cd);
        $display("test byte lanes done");
        acc(1'b1, 12'h5c8, 32'hffff, 4'hf);
        rd(12'h5c8, 32'h0);
        rd(12'h5c4, {24'h0, ev[9][7:0]});
        $display("test unmapped done");
        @(posedge clock);
        conclude();
    end
endmodule : tb_top
